// ==== rtl/pkwv_pkg.sv ====
package pkwv_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int SAMPLE_W = 24;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 12;
  localparam int STATUS_W = 4;
  // ************************************************************
  // register indices; byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_MEAS_MODE = 8'h14;
  localparam logic [7:0] IDX_WAVE_MODE = 8'h15;
  localparam logic [7:0] IDX_HALF_CYC = 8'h1C;
  localparam logic [7:0] IDX_VOLT_THR = 8'h1D;
  localparam logic [7:0] IDX_CURR_THR = 8'h1E;
  localparam logic [7:0] IDX_VOLT_PEAK = 8'h1F;
  localparam logic [7:0] IDX_CURR_PEAK = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
  localparam logic [7:0] IDX_WAVE_DATA = 8'h23;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int FREQ_LSB = 0;
  localparam int PEAK_SEL_LSB = 2;
  localparam int IRQ_SEL_LSB = 5;
  localparam int PHASE_LSB = 0;
  localparam int TYPE_LSB = 2;
  localparam int RATE_LSB = 5;
  localparam int APPARENT_BIT = 7;
  localparam int ST_VOLTAGE_PEAK_VALUE_OVER = 0;
  localparam int ST_CURRENT_PEAK_VALUE_OVER = 1;
  localparam int ST_WINDOW_DONE = 2;
  localparam int ST_WAVE_READY = 3;
  // ************************************************************
  // reset values and timing counts
  // ************************************************************
  localparam logic [7:0] MEAS_MODE_RST = 8'hFC;
  localparam logic [7:0] WAVE_MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0] HALF_CYC_RST = 16'h0064;
  localparam logic [SAMPLE_W-1:0] THRESH_RST = 24'hFFFFFF;
  localparam int CLK_PRE_DIV = 3;
  localparam int RATE_BASE_DIV = 128;

  typedef enum logic [1:0] {PH_A = 2'b00, PH_B = 2'b01, PH_C = 2'b10, PH_RSVD = 2'b11} wave_phase_t;
  typedef enum logic [2:0] {
    WV_CURR = 3'b000, WV_VOLT = 3'b001, WV_ACTIVE = 3'b010, WV_REACTIVE = 3'b011,
    WV_APPARENT = 3'b100
  } wave_type_t;

  // magnitude of a signed sample; full negative scale still fits unsigned
  function automatic logic [SAMPLE_W-1:0] mag(input logic [SAMPLE_W-1:0] x);
    mag = x[SAMPLE_W-1] ? (~x + 24'h000001) : x;
  endfunction
endpackage

// ==== rtl/phase_samples_if.sv ====
`timescale 1ns/1ns
interface phase_samples_if;
  import pkwv_pkg::*;
  logic [2:0][SAMPLE_W-1:0] volt;
  logic [2:0][SAMPLE_W-1:0] curr;
  logic valid;
  logic half_tick;
  modport src(output volt, output curr, output valid, output half_tick);
  modport dst(input volt, input curr, input valid, input half_tick);
endinterface

// ==== rtl/sample_strobe_gen.sv ====
`timescale 1ns/1ns
module sample_strobe_gen import pkwv_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // rate code and strobe
  input wire logic [1:0] rate,
  output logic strobe
);
  logic [1:0] pre_reg, pre_next;
  logic [9:0] cnt_reg, cnt_next;
  logic [9:0] limit;

  // clock / 3, then / (128 << rate)
  always_comb begin
    limit = 10'((RATE_BASE_DIV << rate) - 1);
    pre_next = (pre_reg == 2'(CLK_PRE_DIV - 1)) ? 2'h0 : pre_reg + 2'h1;
    cnt_next = cnt_reg;
    strobe = 1'b0;
    if (pre_reg == 2'(CLK_PRE_DIV - 1)) begin
      // a lower rate code mid-count ends the current period early
      if (cnt_reg >= limit) begin
        cnt_next = 10'h000;
        strobe = 1'b1;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 2'h0;
      cnt_reg <= 10'h000;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end

  a_strobe_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    strobe |=> !strobe [*8]) else $error("strobe spacing too short");
endmodule

// ==== rtl/peak_tracker.sv ====
`timescale 1ns/1ns
module peak_tracker import pkwv_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // samples and control
  phase_samples_if.dst s,
  input wire logic [2:0] enable,
  input wire logic [CNT_W-1:0] half_count,
  // held peaks
  output logic [SAMPLE_W-1:0] voltage_peak_value_reg,
  output logic [SAMPLE_W-1:0] current_peak_value_reg,
  output logic window_done
);
  logic [SAMPLE_W-1:0] vrun_reg, vrun_next, irun_reg, irun_next, voltage_peak_value_next, current_peak_value_next;
  logic [CNT_W-1:0] hcnt_reg, hcnt_next;
  logic [SAMPLE_W-1:0] vm, im;

  // running maxima; voltage and current pick their phase independently
  always_comb begin
    vrun_next = vrun_reg;
    irun_next = irun_reg;
    voltage_peak_value_next = voltage_peak_value_reg;
    current_peak_value_next = current_peak_value_reg;
    hcnt_next = hcnt_reg;
    window_done = 1'b0;
    if (s.valid) begin
      for (int p = 0; p < 3; p++) begin
        vm = mag(s.volt[p]);
        im = mag(s.curr[p]);
        if (enable[p] && vm > vrun_next) vrun_next = vm;
        if (enable[p] && im > irun_next) irun_next = im;
      end
    end else begin
      vm = '0;
      im = '0;
    end
    if (s.half_tick) begin
      // a zero count behaves as a one-half-cycle window
      if (hcnt_reg + 16'h0001 >= half_count) begin
        window_done = 1'b1;
        hcnt_next = '0;
        voltage_peak_value_next = vrun_next;
        current_peak_value_next = irun_next;
        vrun_next = '0;
        irun_next = '0;
      end else begin
        hcnt_next = hcnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vrun_reg <= '0;
      irun_reg <= '0;
      voltage_peak_value_reg <= '0;
      current_peak_value_reg <= '0;
      hcnt_reg <= '0;
    end else begin
      vrun_reg <= vrun_next;
      irun_reg <= irun_next;
      voltage_peak_value_reg <= voltage_peak_value_next;
      current_peak_value_reg <= current_peak_value_next;
      hcnt_reg <= hcnt_next;
    end
  end

  a_peak_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !window_done |=> $stable(voltage_peak_value_reg) && $stable(current_peak_value_reg))
    else $error("held peak changed inside window");
  a_phase_a_track: assert property (@(posedge pclk) disable iff (!presetn)
    (s.valid && enable[0] && !window_done) |=> vrun_reg >= $past(mag(s.volt[0])))
    else $error("phase A voltage peak missed");
  a_phase_c_track: assert property (@(posedge pclk) disable iff (!presetn)
    (s.valid && enable[2] && !window_done) |=> irun_reg >= $past(mag(s.curr[2])))
    else $error("phase C current peak missed");
  a_idle_when_off: assert property (@(posedge pclk) disable iff (!presetn)
    (enable == 3'b000 && !window_done) |=> $stable(vrun_reg) && $stable(irun_reg))
    else $error("peak moved with no phase enabled");
endmodule

// ==== rtl/peak_wave_cfg.sv ====
`timescale 1ns/1ns
module peak_wave_cfg import pkwv_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-phase samples, signed
  input wire logic [2:0][SAMPLE_W-1:0] volt_in,
  input wire logic [2:0][SAMPLE_W-1:0] curr_in,
  input wire logic [2:0][SAMPLE_W-1:0] active_in,
  input wire logic [2:0][SAMPLE_W-1:0] reactive_in,
  input wire logic [2:0][SAMPLE_W-1:0] apparent_in,
  input wire logic sample_valid,
  input wire logic half_cycle_tick,
  // pulse sources
  input wire logic reactive_pulse_in,
  input wire logic apparent_pulse_in,
  // outputs
  output logic [SAMPLE_W-1:0] wave_data,
  output logic wave_valid,
  output logic second_pulse_output,
  output logic [1:0] frequency_source_field,
  output logic irq
);
  // ************************************************************
  // address decode
  // ************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, IDX_MEAS_MODE) || hit(a, IDX_WAVE_MODE) || hit(a, IDX_HALF_CYC)
      || hit(a, IDX_VOLT_THR) || hit(a, IDX_CURR_THR) || hit(a, IDX_VOLT_PEAK)
      || hit(a, IDX_CURR_PEAK) || hit(a, IDX_IRQ_STATUS) || hit(a, IDX_IRQ_MASK)
      || hit(a, IDX_WAVE_DATA);
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] meas_mode_reg, meas_mode_next;
  logic [7:0] wave_mode_reg, wave_mode_next;
  logic [CNT_W-1:0] half_cyc_reg, half_cyc_next;
  logic [SAMPLE_W-1:0] vthr_reg, vthr_next, ithr_reg, ithr_next;
  logic [STATUS_W-1:0] status_reg, status_next, mask_reg, mask_next, status_set;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic [SAMPLE_W-1:0] wave_reg, wave_next;
  logic wave_valid_reg, wave_valid_next;
  logic pulse_reg, pulse_next;
  logic wr_access, setup;
  logic [2:0] peak_sel, irq_sel;
  wave_phase_t phase;
  wave_type_t wtype;
  logic [1:0] rate;
  logic strobe, window_done;
  logic [SAMPLE_W-1:0] voltage_peak_value, current_peak_value;
  logic vover, iover;

  phase_samples_if ps ();

  // ************************************************************
  // field views
  // ************************************************************
  assign peak_sel = meas_mode_reg[PEAK_SEL_LSB +: 3];
  assign irq_sel = meas_mode_reg[IRQ_SEL_LSB +: 3];
  assign phase = wave_phase_t'(wave_mode_reg[PHASE_LSB +: 2]);
  assign wtype = wave_type_t'(wave_mode_reg[TYPE_LSB +: 3]);
  assign rate = wave_mode_reg[RATE_LSB +: 2];
  assign frequency_source_field = meas_mode_reg[FREQ_LSB +: 2];

  // sample bundle shared with the peak tracker
  assign ps.volt = volt_in;
  assign ps.curr = curr_in;
  assign ps.valid = sample_valid;
  assign ps.half_tick = half_cycle_tick;

  // ************************************************************
  // submodules
  // ************************************************************
  sample_strobe_gen u_strobe (
    .pclk(pclk),
    .presetn(presetn),
    .rate(rate),
    .strobe(strobe)
  );

  peak_tracker u_peak (
    .pclk(pclk),
    .presetn(presetn),
    .s(ps.dst),
    .enable(peak_sel),
    .half_count(half_cyc_reg),
    .voltage_peak_value_reg(voltage_peak_value),
    .current_peak_value_reg(current_peak_value),
    .window_done(window_done)
  );

  // ************************************************************
  // threshold monitor
  // ************************************************************
  // any selected phase may raise either flag
  always_comb begin
    vover = 1'b0;
    iover = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (sample_valid && irq_sel[p]) begin
        if (mag(volt_in[p]) > vthr_reg) vover = 1'b1;
        if (mag(curr_in[p]) > ithr_reg) iover = 1'b1;
      end
    end
    status_set = '0;
    status_set[ST_VOLTAGE_PEAK_VALUE_OVER] = vover;
    status_set[ST_CURRENT_PEAK_VALUE_OVER] = iover;
    status_set[ST_WINDOW_DONE] = window_done;
    status_set[ST_WAVE_READY] = strobe;
  end

  // ************************************************************
  // apb register file
  // ************************************************************
  // no wait states: pready is always high, read data captured at setup
  assign pready = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign setup = psel && !penable;

  always_comb begin
    meas_mode_next = meas_mode_reg;
    wave_mode_next = wave_mode_reg;
    half_cyc_next = half_cyc_reg;
    vthr_next = vthr_reg;
    ithr_next = ithr_reg;
    mask_next = mask_reg;
    // set wins over a simultaneous write-one clear
    status_next = status_reg | status_set;
    if (wr_access) begin
      if (hit(paddr, IDX_MEAS_MODE)) begin
        meas_mode_next = pwdata[7:0];
      end else if (hit(paddr, IDX_WAVE_MODE)) begin
        wave_mode_next = pwdata[7:0];
      end else if (hit(paddr, IDX_HALF_CYC)) begin
        half_cyc_next = pwdata[CNT_W-1:0];
      end else if (hit(paddr, IDX_VOLT_THR)) begin
        vthr_next = pwdata[SAMPLE_W-1:0];
      end else if (hit(paddr, IDX_CURR_THR)) begin
        ithr_next = pwdata[SAMPLE_W-1:0];
      end else if (hit(paddr, IDX_IRQ_STATUS)) begin
        status_next = (status_reg & ~pwdata[STATUS_W-1:0]) | status_set;
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
        mask_next = pwdata[STATUS_W-1:0];
      end
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup) begin
      pslverr_next = !mapped(paddr);
      prdata_next = 32'h00000000;
      if (hit(paddr, IDX_MEAS_MODE)) begin
        prdata_next[7:0] = meas_mode_reg;
      end else if (hit(paddr, IDX_WAVE_MODE)) begin
        prdata_next[7:0] = wave_mode_reg;
      end else if (hit(paddr, IDX_HALF_CYC)) begin
        prdata_next[CNT_W-1:0] = half_cyc_reg;
      end else if (hit(paddr, IDX_VOLT_THR)) begin
        prdata_next[SAMPLE_W-1:0] = vthr_reg;
      end else if (hit(paddr, IDX_CURR_THR)) begin
        prdata_next[SAMPLE_W-1:0] = ithr_reg;
      end else if (hit(paddr, IDX_VOLT_PEAK)) begin
        prdata_next[SAMPLE_W-1:0] = voltage_peak_value;
      end else if (hit(paddr, IDX_CURR_PEAK)) begin
        prdata_next[SAMPLE_W-1:0] = current_peak_value;
      end else if (hit(paddr, IDX_IRQ_STATUS)) begin
        prdata_next[STATUS_W-1:0] = status_reg;
      end else if (hit(paddr, IDX_IRQ_MASK)) begin
        prdata_next[STATUS_W-1:0] = mask_reg;
      end else if (hit(paddr, IDX_WAVE_DATA)) begin
        prdata_next[SAMPLE_W-1:0] = wave_reg;
      end
    end
  end

  // ************************************************************
  // waveform sampling and pulse select
  // ************************************************************
  // reserved phase or type codes leave the last sample in place
  always_comb begin
    wave_next = wave_reg;
    wave_valid_next = 1'b0;
    if (strobe && phase != PH_RSVD) begin
      wave_valid_next = 1'b1;
      case (wtype)
        WV_CURR: wave_next = curr_in[phase];
        WV_VOLT: wave_next = volt_in[phase];
        WV_ACTIVE: wave_next = active_in[phase];
        WV_REACTIVE: wave_next = reactive_in[phase];
        WV_APPARENT: wave_next = apparent_in[phase];
        default: wave_valid_next = 1'b0;
      endcase
    end
    pulse_next = wave_mode_reg[APPARENT_BIT] ? apparent_pulse_in : reactive_pulse_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_mode_reg <= MEAS_MODE_RST;
      wave_mode_reg <= WAVE_MODE_RST;
      half_cyc_reg <= HALF_CYC_RST;
      vthr_reg <= THRESH_RST;
      ithr_reg <= THRESH_RST;
      status_reg <= '0;
      mask_reg <= '0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
      wave_reg <= '0;
      wave_valid_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      meas_mode_reg <= meas_mode_next;
      wave_mode_reg <= wave_mode_next;
      half_cyc_reg <= half_cyc_next;
      vthr_reg <= vthr_next;
      ithr_reg <= ithr_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      wave_reg <= wave_next;
      wave_valid_reg <= wave_valid_next;
      pulse_reg <= pulse_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;
  assign wave_data = wave_reg;
  assign wave_valid = wave_valid_reg;
  assign second_pulse_output = pulse_reg;
  assign irq = |(status_reg & mask_reg);

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_sel_phase_b_over;
    sample_valid && irq_sel == 3'b010 && mag(volt_in[1]) > vthr_reg;
  endsequence

  sequence s_flag_up;
    status_reg[ST_VOLTAGE_PEAK_VALUE_OVER] ##1 status_reg[ST_VOLTAGE_PEAK_VALUE_OVER];
  endsequence

  a_thresh_flag: assert property (@(posedge pclk) disable iff (!presetn)
    s_sel_phase_b_over |=> s_flag_up) else $error("voltage over flag not set");
  a_irq_select: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_sel == 3'b000 && !status_reg[ST_CURRENT_PEAK_VALUE_OVER] && !wr_access)
    |=> !status_reg[ST_CURRENT_PEAK_VALUE_OVER]) else $error("flag set from deselected phase");
  a_wave_phase_b: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && phase == PH_B && wtype == WV_VOLT)
    |=> wave_valid && wave_data == $past(volt_in[1]))
    else $error("phase B voltage sample wrong");
  a_wave_type_cur: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && phase == PH_A && wtype == WV_CURR) |=> wave_data == $past(curr_in[0]))
    else $error("phase A current sample wrong");
  a_pulse_select: assert property (@(posedge pclk) disable iff (!presetn)
    !wave_mode_reg[APPARENT_BIT] |=> second_pulse_output == $past(reactive_pulse_in))
    else $error("second pulse not reactive");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (status_set[ST_VOLTAGE_PEAK_VALUE_OVER] && mask_reg[ST_VOLTAGE_PEAK_VALUE_OVER] && !wr_access) |=> irq)
    else $error("unmasked status without interrupt");

  // ************************************************************
  // mode register and sampling path checks
  // ************************************************************
  // a field written over the bus is what the datapath decodes next cycle
  sequence s_mode_write;
    wr_access && hit(paddr, IDX_MEAS_MODE);
  endsequence

  a_peak_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_mode_write |=> peak_sel == $past(pwdata[PEAK_SEL_LSB +: 3]))
    else $error("peak phase select not stored");
  a_irq_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_mode_write |=> irq_sel == $past(pwdata[IRQ_SEL_LSB +: 3]))
    else $error("peak interrupt select not stored");
  a_wave_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && hit(paddr, IDX_WAVE_MODE)) |=> wave_mode_reg == $past(pwdata[7:0]))
    else $error("waveform mode not stored");

  // the sticky flags only fall on a bus write, so a missed clear is visible
  a_curr_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_valid && irq_sel[1] && mag(curr_in[1]) > ithr_reg) |=> status_reg[ST_CURRENT_PEAK_VALUE_OVER])
    else $error("current over flag not set");
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (status_reg[ST_VOLTAGE_PEAK_VALUE_OVER] && !wr_access) |=> status_reg[ST_VOLTAGE_PEAK_VALUE_OVER])
    else $error("voltage over flag fell without a clear");
  a_window_flag: assert property (@(posedge pclk) disable iff (!presetn)
    window_done |=> status_reg[ST_WINDOW_DONE])
    else $error("window end not flagged");

  // each defined type and phase code routes its own input, as seen in the strobe cycle
  sequence s_strobe_apparent_c;
    strobe && phase == PH_C && wtype == WV_APPARENT;
  endsequence

  a_wave_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && phase == PH_A && wtype == WV_ACTIVE) |=> wave_data == $past(active_in[0]))
    else $error("phase A active sample wrong");
  a_wave_react_b: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && phase == PH_B && wtype == WV_REACTIVE) |=> wave_data == $past(reactive_in[1]))
    else $error("phase B reactive sample wrong");
  a_wave_appar_c: assert property (@(posedge pclk) disable iff (!presetn)
    s_strobe_apparent_c |=> wave_valid && wave_data == $past(apparent_in[2]))
    else $error("phase C apparent sample wrong");
  a_wave_phase_c: assert property (@(posedge pclk) disable iff (!presetn)
    (strobe && phase == PH_C && wtype == WV_CURR) |=> wave_data == $past(curr_in[2]))
    else $error("phase C current sample wrong");
  a_wave_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !strobe |=> !wave_valid)
    else $error("sample flagged without a strobe");

  a_pulse_apparent: assert property (@(posedge pclk) disable iff (!presetn)
    wave_mode_reg[APPARENT_BIT] |=> second_pulse_output == $past(apparent_pulse_in))
    else $error("second pulse not apparent");
endmodule

// ==== test/peak_wave_cfg_tb.sv ====
`timescale 1ns/1ns
module peak_wave_cfg_tb import pkwv_pkg::*;;
  // ************************************************************
  // clock, reset and design ports
  // ************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0][SAMPLE_W-1:0] volt_in, curr_in, active_in, reactive_in, apparent_in;
  logic sample_valid, half_cycle_tick, reactive_pulse_in, apparent_pulse_in;
  logic [SAMPLE_W-1:0] wave_data;
  logic wave_valid, second_pulse_output, irq;
  logic [1:0] frequency_source_field;
  int err_count = 0;
  int checked = 0;
  logic [31:0] rdv;
  logic erv;
  int n;

  peak_wave_cfg i_peak_wave_cfg (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .volt_in(volt_in), .curr_in(curr_in), .active_in(active_in),
    .reactive_in(reactive_in), .apparent_in(apparent_in), .sample_valid(sample_valid),
    .half_cycle_tick(half_cycle_tick), .reactive_pulse_in(reactive_pulse_in),
    .apparent_pulse_in(apparent_pulse_in), .wave_data(wave_data), .wave_valid(wave_valid),
    .second_pulse_output(second_pulse_output), .frequency_source_field(frequency_source_field),
    .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ************************************************************
  // report helpers
  // ************************************************************
  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // ************************************************************
  // apb master; request held until pready is seen high
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      err_count++;
      conclude();
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask

  // one-cycle pulses on the sample and half-cycle strobes
  task automatic samp();
    @(posedge pclk);
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask

  task automatic ticks(input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      half_cycle_tick <= 1'b1;
      @(posedge pclk);
      half_cycle_tick <= 1'b0;
    end
  endtask

  // counts edges up to the next wave_valid; n equals lim when none came
  task automatic wv(input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (wave_valid !== 1'b1 && n < lim);
  endtask

  task automatic wwait();
    wv(4000);
    if (n >= 4000) begin
      err_count++;
      conclude();
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sample_valid, half_cycle_tick} = 5'h00;
    {reactive_pulse_in, apparent_pulse_in} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0;
    // distinct value per phase for active, reactive and apparent so a wrong pick is visible
    for (int p = 0; p < 3; p++) begin
      volt_in[p] = 24'h0;
      curr_in[p] = 24'h0;
      active_in[p] = 24'h130000 + 24'(p);
      reactive_in[p] = 24'h140000 + 24'(p);
      apparent_in[p] = 24'h150000 + 24'(p);
    end
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and read-only places
    rchk(IDX_MEAS_MODE, 32'h000000FC);
    rchk(IDX_WAVE_MODE, 32'h00000000);
    rchk(IDX_HALF_CYC, 32'h00000064);
    rchk(8'h30, 32'h0);
    chk({31'h0, erv}, 32'h1);
    apb(1'b1, IDX_VOLT_PEAK, 32'h123);
    rchk(IDX_VOLT_PEAK, 32'h0);
    // phase A only: B carries larger values that must be ignored
    apb(1'b1, IDX_MEAS_MODE, 32'h04);
    apb(1'b1, IDX_HALF_CYC, 32'h2);
    volt_in <= {24'h0, 24'h000100, 24'hFFFFFB};
    curr_in <= {24'h0, 24'h000200, 24'h000007};
    samp();
    ticks(2);
    rchk(IDX_VOLT_PEAK, 32'h5);
    rchk(IDX_CURR_PEAK, 32'h7);
    chk({30'h0, frequency_source_field}, 32'h0);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk(rdv & 32'h4, 32'h4);
    // all phases: voltage max on A, current max on C
    apb(1'b1, IDX_MEAS_MODE, 32'h1E);
    volt_in <= {24'hFFFFFE, 24'h000003, 24'h000009};
    curr_in <= {24'hFFFFD0, 24'h000002, 24'h000001};
    samp();
    ticks(2);
    rchk(IDX_VOLT_PEAK, 32'h9);
    rchk(IDX_CURR_PEAK, 32'h30);
    chk({30'h0, frequency_source_field}, 32'h2);
    // thresholds on phase B only; compare is strict
    apb(1'b1, IDX_VOLT_THR, 32'hA);
    apb(1'b1, IDX_CURR_THR, 32'hA);
    apb(1'b1, IDX_MEAS_MODE, 32'h40);
    apb(1'b1, IDX_IRQ_STATUS, 32'hF);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    volt_in <= {24'h0, 24'h00000A, 24'h000064};
    curr_in <= {24'h0, 24'h00000B, 24'h0};
    samp();
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk(rdv & 32'h3, 32'h2);
    chk({31'h0, irq}, 32'h0);
    volt_in <= {24'h0, 24'hFFFFF5, 24'h0};
    samp();
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_IRQ_STATUS, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    // every phase and type; first strobe after a write may be stale
    volt_in <= {24'h120002, 24'h120001, 24'h120000};
    curr_in <= {24'h110002, 24'h110001, 24'h110000};
    for (int t = 0; t < 5; t++) begin
      for (int p = 0; p < 3; p++) begin
        apb(1'b1, IDX_WAVE_MODE, {27'h0, 3'(t), 2'(p)});
        wwait();
        wwait();
        chk({8'h0, wave_data}, 32'h110000 + 32'(t) * 32'h10000 + 32'(p));
      end
    end
    rchk(IDX_WAVE_DATA, 32'h00150002);
    // strobe period for each rate code
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, IDX_WAVE_MODE, {25'h0, 2'(r), 5'h04});
      wwait();
      wwait();
      wwait();
      chk(32'(n), 32'(CLK_PRE_DIV * (RATE_BASE_DIV << r)));
    end
    // software keeps reserved codes out; a rate-0 period outlasts 300 cycles
    apb(1'b1, IDX_WAVE_MODE, 32'h04);
    wwait();
    wwait();
    wv(300);
    chk(32'(n), 32'd300);
    // second pulse output source select
    apb(1'b1, IDX_WAVE_MODE, 32'h00);
    reactive_pulse_in <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, second_pulse_output}, 32'h1);
    apb(1'b1, IDX_WAVE_MODE, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, second_pulse_output}, 32'h0);
    apparent_pulse_in <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, second_pulse_output}, 32'h1);
    conclude();
  end
endmodule
